// ---- logic/mppc_cfg.svh ----
// constants for the mode and partition protection controller
`ifndef MPPC_CFG_SVH
`define MPPC_CFG_SVH
// ----------------
// clock and timing
// ----------------
`define MPPC_CLK_PERIOD_NS  100
`define MPPC_EXT_ACC_NS     300
`define MPPC_EXT_ACC_CYC    ((`MPPC_EXT_ACC_NS + `MPPC_CLK_PERIOD_NS - 1) / `MPPC_CLK_PERIOD_NS)
// ----------------
// window map (13-bit offsets)
// ----------------
`define MPPC_ADDR_MODE_CTL  13'h100C
`define MPPC_ADDR_MODE_CNF  13'h1072
`define MPPC_ADDR_OUT_CTL   13'h1016
`define MPPC_ADDR_PD_CTL    13'h1018
`define MPPC_ADDR_KEY0      13'h1020
`define MPPC_ADDR_KEY1      13'h1022
`define MPPC_ADDR_WAKE      13'h1FFF
`define MPPC_SEC_LO         13'h0800
`define MPPC_SEC_HI         13'h17FF
// ----------------
// fields and reset values
// ----------------
`define MPPC_MODE_LSB       0
`define MPPC_SESSION_LOCK_BIT_BIT      0
`define MPPC_PD_EN_BIT      0
`define MPPC_PD_POL_BIT     1
`define MPPC_WAKE_READS     3'h4
`define MPPC_REG_RST        8'h00
`define MPPC_READ_ZERO      8'h00
// ----------------
// reserved flash blocks
// ----------------
`define MPPC_BLK_BBT        10'h000
`define MPPC_BLK_PROT0_A    10'h001
`define MPPC_BLK_PROT0_B    10'h002
`define MPPC_BLK_PROT1_A    10'h003
`define MPPC_BLK_PROT1_B    10'h004
`define MPPC_UID_BYTES      16
`define MPPC_OTP_PG_FIRST   8
`define MPPC_OTP_PG_LAST    31
`define MPPC_LOADER_BYTES   2048
`endif

// ---- logic/mppc_pkg.sv ----
// types shared by the mode and partition protection controller
package mppc_pkg;
    // ----------------
    // operating mode, binary coded
    // ----------------
    typedef enum logic [1:0] {
        MPPC_RESET  = 2'b00,
        MPPC_NORMAL = 2'b01,
        MPPC_PDOWN  = 2'b10
    } mppc_mode_t;
    // ----------------
    // per-partition attributes fixed at format time
    // ----------------
    typedef struct packed {
        logic       rd_prot;  // reads need key
        logic       wr_prot;  // writes need key
        logic       lock_en;  // lock option enabled
        logic [7:0] key;      // partition key
    } mppc_part_cfg_t;
    // ----------------
    // classes of reserved flash blocks
    // ----------------
    typedef enum logic [1:0] {
        MPPC_BLK_USER   = 2'b00,
        MPPC_BLK_MAP    = 2'b01,
        MPPC_BLK_PROT0  = 2'b10,
        MPPC_BLK_LOADER = 2'b11
    } mppc_blk_t;
endpackage

// ---- logic/mppc_ctrl.sv ----
// mode sequencer and partition protection for the flash disk controller
`timescale 1ns/1ps
`include "mppc_cfg.svh"

// What this block does
// RULE1: two partitions, separate read/write protect, keys
// RULE2: correct key lifts protection, removal restores it
// RULE3: lock option plus lock pin denies access
// RULE4: session lock acts as pin, reset clears
// RULE5: power-down, attribute change, loader write, removal drop keys
// RULE6: host holds lock pin while formatting locked partitions
// RULE7: exactly one of three modes, always readable
// RULE8: reset pin or power-up enters reset mode
// RULE9: normal only after control plus confirmation write
// RULE10: normal returns to reset by writes or boot detect
// RULE11: power-down by write sequence then chip select high
// RULE12: reset held in normal gives power-down, release reset
// RULE13: four reads of 1FFF wake into normal
// RULE14: one extended boot read wakes, standard interface only
// RULE15: power-down pin moves between power-down and normal
// RULE16: cycles are select with write or output strobe
// RULE17: reset mode takes only mode writes, reads zero
// RULE18: power-down ignores writes, leaves data undriven
// RULE19: power-down round trip keeps all registers; the code loads the key registers with non-matching values on entry
// RULE20: power-down with select high disables input buffers
// RULE21: booting host clears power-down before vector fetch
// RULE22: first five blocks hold reserved structures
// RULE23: bus-triggered mode change follows cycle end
module mppc_ctrl #(
    parameter int NPART = 2,   // protected partitions
    parameter int DW    = 16,  // data bus width
    parameter int BW    = 10   // flash block index width
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // host bus, synchronous samples
    input  wire logic                      ce_n,
    input  wire logic                      we_n,
    input  wire logic                      oe_n,
    input  wire logic                      addr_valid_n,
    input  wire logic [12:0]               addr,
    input  wire logic [DW-1:0]             data_in,
    output logic      [DW-1:0]             data_out,
    output logic                           data_oe,
    input  wire logic                      mux_if,
    // boot block read data
    input  wire logic [DW-1:0]             boot_rd_data,
    // system pins
    input  wire logic                      hw_reset_in_n,
    input  wire logic                      lock_in_n,
    input  wire logic                      power_down_pin,
    input  wire logic                      boot_detect,
    // partition attributes and events
    input  wire mppc_pkg::mppc_part_cfg_t  part_cfg [NPART],
    input  wire logic                      attr_change,
    input  wire logic                      flash_wr,
    input  wire logic [BW-1:0]             flash_wr_block,
    // status
    output mppc_pkg::mppc_mode_t           mode,
    output logic      [NPART-1:0]          part_rd_ok,
    output logic      [NPART-1:0]          part_wr_ok,
    output logic                           session_lock_bit,
    output logic                           in_buf_en
);
    import mppc_pkg::*;

    initial begin
        if (NPART != 2 || DW < 8 || BW < 3)
            $error("mppc_ctrl: unsupported parameters");
    end

    // ----------------
    // reset release
    // ----------------
    logic rst_s1;  // first stage, read only by rst_s2
    logic rst_s2;  // internal reset, active low

    // async assert, two-flop release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // ----------------
    // decode helpers
    // ----------------
    // register window sits in sections 1 and 2
    function automatic logic is_reg(input logic [12:0] a);
        is_reg = (a >= `MPPC_SEC_LO) && (a <= `MPPC_SEC_HI);
    endfunction

    // class of a flash block in the reserved area
    function automatic mppc_blk_t blk_kind(input logic [BW-1:0] b);
        if (b == BW'(`MPPC_BLK_BBT))
            blk_kind = MPPC_BLK_MAP;
        else if (b == BW'(`MPPC_BLK_PROT0_A) || b == BW'(`MPPC_BLK_PROT0_B))
            blk_kind = MPPC_BLK_PROT0;
        else if (b == BW'(`MPPC_BLK_PROT1_A) || b == BW'(`MPPC_BLK_PROT1_B))
            blk_kind = MPPC_BLK_LOADER;
        else
            blk_kind = MPPC_BLK_USER;
    endfunction

    // ----------------
    // bus cycle tracking
    // ----------------
    logic        pdown_q;   // power-down with buffers gated
    logic        wr_act;    // write strobes asserted
    logic        rd_act;    // read strobes asserted
    logic        wr_q;      // write active last cycle
    logic        rd_q;      // read active last cycle
    logic [12:0] cyc_addr;  // address held for the cycle
    logic [7:0]  cyc_data;  // write data held for the cycle
    logic [2:0]  rd_len;    // saturating length of a read
    logic        wr_end;    // write cycle just finished
    logic        rd_end;    // read cycle just finished

    // gated buffers see nothing while powered down and deselected
    assign pdown_q = (mode == MPPC_PDOWN) && ce_n;  // RULE20
    assign wr_act  = !ce_n && !we_n && !pdown_q;    // RULE16
    assign rd_act  = !ce_n && !oe_n && !pdown_q;    // RULE16
    assign wr_end  = wr_q && !wr_act;               // RULE23
    assign rd_end  = rd_q && !rd_act;               // RULE23

    // cycle state; data captured while the strobe is low
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cyc_addr <= 13'h0000;
            cyc_data <= `MPPC_REG_RST;
        end else begin
            wr_q <= wr_act;
            rd_q <= rd_act;
            // on the muxed bus the address is taken while valid is low
            if ((wr_act || rd_act) && (!mux_if || !addr_valid_n))
                cyc_addr <= addr;
            if (wr_act)
                cyc_data <= data_in[7:0];
        end
    end

    // read length, for the extended access wake
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2)
            rd_len <= 3'h0;
        else if (!rd_act)
            rd_len <= 3'h0;
        else if (rd_len != 3'h7)
            rd_len <= rd_len + 3'h1;
    end

    // ----------------
    // registers written by the host
    // ----------------
    logic [1:0]       mode_req;   // requested mode field
    logic             cnf_ok;     // confirmation matched
    logic [1:0]       pd_ctl;     // power-down pin enable, polarity
    logic [7:0]       key_reg [NPART];  // keys presented
    logic             reg_wr;     // finished write to a register
    logic             mode_wr_ok; // writes allowed in this mode

    // reset mode takes only the mode pair, power-down takes nothing
    assign mode_wr_ok = (mode == MPPC_NORMAL) ||
                        ((mode == MPPC_RESET) &&
                         (cyc_addr == `MPPC_ADDR_MODE_CTL ||
                          cyc_addr == `MPPC_ADDR_MODE_CNF));  // RULE17 RULE18
    assign reg_wr = wr_end && mode_wr_ok;

    // mode control and its confirmation, a matched pair
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            mode_req <= 2'b00;
            cnf_ok   <= 1'b0;
        end else begin
            cnf_ok <= 1'b0;
            if (reg_wr && cyc_addr == `MPPC_ADDR_MODE_CTL)
                mode_req <= cyc_data[`MPPC_MODE_LSB +: 2];
            // confirmation carries the complement of the request
            if (reg_wr && cyc_addr == `MPPC_ADDR_MODE_CNF)
                cnf_ok <= (cyc_data[`MPPC_MODE_LSB +: 2] == ~mode_req);  // RULE9
        end
    end

    // power-down pin configuration
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2)
            pd_ctl <= 2'b00;
        else if (reg_wr && cyc_addr == `MPPC_ADDR_PD_CTL)
            pd_ctl <= cyc_data[1:0];
    end

    // session lock: set by software, cleared only by the power-up reset or the reset pin
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2)
            session_lock_bit <= 1'b0;
        else if (!hw_reset_in_n)
            session_lock_bit <= 1'b0;  // RULE4
        else if (reg_wr && cyc_addr == `MPPC_ADDR_OUT_CTL &&
                 cyc_data[`MPPC_SESSION_LOCK_BIT_BIT])
            session_lock_bit <= 1'b1;  // RULE4
    end

    // ----------------
    // keys and access grants, one slice per partition
    // ----------------
    logic key_drop;  // event that withdraws every key
    logic ldr_wr;    // write into the loader blocks

    assign ldr_wr   = flash_wr && (blk_kind(flash_wr_block) == MPPC_BLK_LOADER);  // RULE22
    // any key drop re-arms protection on both partitions
    assign key_drop = (mode == MPPC_PDOWN) || attr_change || ldr_wr;  // RULE5

    for (genvar p = 0; p < NPART; p++) begin : g_part
        logic [12:0] key_addr;  // key register of this slice
        logic        locked;    // hardware lock in force
        logic        key_in;    // key matches
        assign key_addr = (p == 0) ? `MPPC_ADDR_KEY0 : `MPPC_ADDR_KEY1;
        assign locked   = part_cfg[p].lock_en &&
                          (!lock_in_n || session_lock_bit);  // RULE3 RULE4 RULE6
        assign key_in   = (key_reg[p] == part_cfg[p].key);   // RULE2

        // key presented by the host; a mismatching write removes it
        always_ff @(posedge clk or negedge rst_s2) begin
            if (!rst_s2)
                key_reg[p] <= `MPPC_REG_RST;
            else if (key_drop)
                key_reg[p] <= ~part_cfg[p].key;  // RULE5
            else if (reg_wr && cyc_addr == key_addr)
                key_reg[p] <= cyc_data;  // RULE2
        end

        // grants follow attributes, key and lock
        always_ff @(posedge clk or negedge rst_s2) begin
            if (!rst_s2) begin
                part_rd_ok[p] <= 1'b0;
                part_wr_ok[p] <= 1'b0;
            end else begin
                part_rd_ok[p] <= !locked && (!part_cfg[p].rd_prot || key_in);  // RULE1
                part_wr_ok[p] <= !locked && (!part_cfg[p].wr_prot || key_in);  // RULE1
            end
        end
    end

    // ----------------
    // mode sequencer
    // ----------------
    mppc_mode_t next_mode;  // mode for the next cycle
    logic       dpd_pend;   // power-down write seen, wait for select high
    logic       by_rst;     // power-down entered by holding the reset pin
    logic [2:0] wake_cnt;   // reads of the wake address
    logic       pd_pin_q;   // previous power-down pin level
    logic       pd_act;     // pin at its active level
    logic       pd_edge;    // pin changed level

    assign pd_act  = power_down_pin ^ pd_ctl[`MPPC_PD_POL_BIT];
    assign pd_edge = pd_ctl[`MPPC_PD_EN_BIT] && (power_down_pin != pd_pin_q);

    // pin history and pending power-down request
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            pd_pin_q <= 1'b0;
            dpd_pend <= 1'b0;
        end else begin
            pd_pin_q <= power_down_pin;
            if (mode != MPPC_NORMAL)
                dpd_pend <= 1'b0;
            else if (cnf_ok && mode_req == MPPC_PDOWN)
                dpd_pend <= 1'b1;  // RULE11
        end
    end

    // counts wake reads; data returned by them is not meaningful
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2)
            wake_cnt <= 3'h0;
        else if (mode != MPPC_PDOWN)
            wake_cnt <= 3'h0;
        else if (rd_end)
            wake_cnt <= (cyc_addr == `MPPC_ADDR_WAKE) ? wake_cnt + 3'h1 : 3'h0;  // RULE13
    end

    // next mode; reset pin outranks all bus events
    always_comb begin
        next_mode = mode;
        case (mode)
            MPPC_RESET: begin
                if (cnf_ok && mode_req == MPPC_NORMAL)
                    next_mode = MPPC_NORMAL;  // RULE9
            end
            MPPC_NORMAL: begin
                if (!hw_reset_in_n)
                    next_mode = MPPC_PDOWN;  // RULE12
                else if (boot_detect || (cnf_ok && mode_req == MPPC_RESET))
                    next_mode = MPPC_RESET;  // RULE10
                else if (dpd_pend && ce_n)
                    next_mode = MPPC_PDOWN;  // RULE11
                else if (pd_edge && pd_act)
                    next_mode = MPPC_PDOWN;  // RULE15
            end
            MPPC_PDOWN: begin
                if (by_rst) begin
                    if (hw_reset_in_n)
                        next_mode = MPPC_RESET;  // RULE12
                end else if (!hw_reset_in_n) begin
                    next_mode = MPPC_RESET;  // RULE8 RULE21
                end else if (rd_end && cyc_addr == `MPPC_ADDR_WAKE &&
                             wake_cnt == `MPPC_WAKE_READS - 3'h1) begin
                    next_mode = MPPC_NORMAL;  // RULE13
                end else if (rd_end && !mux_if && !is_reg(cyc_addr) &&
                             rd_len >= 3'(`MPPC_EXT_ACC_CYC)) begin
                    next_mode = MPPC_NORMAL;  // RULE14
                end else if (pd_edge && !pd_act) begin
                    next_mode = MPPC_NORMAL;  // RULE15
                end
            end
            default: next_mode = MPPC_RESET;
        endcase
        // reset pin outside normal mode lands in reset, unless power-down was entered by holding the reset pin
        if (!hw_reset_in_n && mode != MPPC_NORMAL && !by_rst)
            next_mode = MPPC_RESET;  // RULE8
    end

    // mode register; power-up lands in reset mode
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            mode   <= MPPC_RESET;  // RULE7 RULE8
            by_rst <= 1'b0;
        end else begin
            mode <= next_mode;  // RULE7
            if (mode == MPPC_NORMAL && next_mode == MPPC_PDOWN)
                by_rst <= !hw_reset_in_n;
            else if (next_mode != MPPC_PDOWN)
                by_rst <= 1'b0;
        end
    end

    // ----------------
    // read data path
    // ----------------
    logic [7:0] next_reg;  // register read value

    // register readback; reset mode reads zero everywhere except the mode register
    always_comb begin
        next_reg = `MPPC_READ_ZERO;
        case (addr)
            `MPPC_ADDR_MODE_CTL: next_reg = {6'h00, mode};  // RULE7
            `MPPC_ADDR_OUT_CTL:  next_reg = {7'h00, session_lock_bit};
            `MPPC_ADDR_PD_CTL:   next_reg = {6'h00, pd_ctl};
            default:             next_reg = `MPPC_READ_ZERO;
        endcase
        // mode is visible to software even in reset mode
        if (mode != MPPC_NORMAL && addr != `MPPC_ADDR_MODE_CTL)
            next_reg = `MPPC_READ_ZERO;  // RULE17
    end

    // data bus drive; undriven in power-down, round trip keeps every register except the key registers
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            data_out <= '0;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= rd_act && (mode != MPPC_PDOWN);  // RULE18 RULE19
            if (is_reg(addr))
                data_out <= DW'(next_reg);  // RULE17
            else
                data_out <= boot_rd_data;
        end
    end

    // input buffer enable, gated while idle in power-down
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2)
            in_buf_en <= 1'b1;
        else
            in_buf_en <= !((next_mode == MPPC_PDOWN) && ce_n);  // RULE20
    end
endmodule

// ---- verif/mppc_ctrl_properties.sv ----
// assertion checker for the mode and partition protection controller
`timescale 1ns/1ps
module mppc_ctrl_checker #(
    parameter int NPART = 2  // protected partitions
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rstn,
    // host strobes and system pins
    input wire logic                     ce_n,
    input wire logic                     oe_n,
    input wire logic                     hw_reset_in_n,
    input wire logic                     lock_in_n,
    input wire mppc_pkg::mppc_part_cfg_t part_cfg [NPART],
    // design outputs
    input wire logic                     data_oe,
    input wire mppc_pkg::mppc_mode_t     mode,
    input wire logic [NPART-1:0]         part_rd_ok,
    input wire logic [NPART-1:0]         part_wr_ok,
    input wire logic                     session_lock_bit,
    input wire logic                     in_buf_en
);
    import mppc_pkg::*;
    // ----------------
    // one clock domain, power-up reset rstn disables everything
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    mode_legal_a: assert property (mode != 2'b11)
        else $error("mode holds an illegal code");
    oe_start_a: assert property ($rose(data_oe) |-> !$past(ce_n) && !$past(oe_n))
        else $error("drive without read");
    oe_end_a: assert property ($past(ce_n) || $past(oe_n) |-> !data_oe)
        else $error("drive after read end");
    pd_quiet_a: assert property (mode == MPPC_PDOWN && $past(mode) == MPPC_PDOWN |-> !data_oe)
        else $error("bus driven in power-down");
    buf_off_a: assert property (!in_buf_en |-> mode == MPPC_PDOWN || $past(mode) == MPPC_PDOWN)
        else $error("input buffers off outside power-down");
    // four samples allow for a pin synchroniser
    lock_deny_a: assert property ((part_cfg[0].lock_en && (!lock_in_n || session_lock_bit)) [*4]
        |-> !part_rd_ok[0] && !part_wr_ok[0])
        else $error("locked partition still granted");
    hw_pd_a: assert property ($fell(hw_reset_in_n) && mode == MPPC_NORMAL |-> ##[1:3] mode == MPPC_PDOWN)
        else $error("reset pin in normal did not power down");
    hw_rst_a: assert property ($rose(hw_reset_in_n) && mode == MPPC_PDOWN |-> ##[1:3] mode == MPPC_RESET)
        else $error("reset pin release did not enter reset mode");
    lock_clear_a: assert property (!hw_reset_in_n [*3] |-> !session_lock_bit)
        else $error("session lock survived reset pin");
    lock_hold_a: assert property (session_lock_bit && hw_reset_in_n |=> session_lock_bit)
        else $error("session lock cleared without reset");
endmodule
bind mppc_ctrl mppc_ctrl_checker #(.NPART(NPART)) u_checker (
    .clk(clk), .rstn(rstn), .ce_n(ce_n), .oe_n(oe_n), .hw_reset_in_n(hw_reset_in_n),
    .lock_in_n(lock_in_n), .part_cfg(part_cfg), .data_oe(data_oe), .mode(mode),
    .part_rd_ok(part_rd_ok), .part_wr_ok(part_wr_ok), .session_lock_bit(session_lock_bit),
    .in_buf_en(in_buf_en)
);

// ---- verif/mppc_host_model.sv ----
// host cpu model driving the asynchronous memory bus
`timescale 1ns/1ps
module mppc_host_model (
    // clock
    input  wire logic        clk,
    // strobes and address
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n,
    output logic             addr_valid_n,
    output logic [12:0]      addr,
    // data both ways
    output logic [15:0]      data_in,
    input  wire logic [15:0] data_out
);
    // ----------------
    // bus phases
    // ----------------
    initial begin
        ce_n = 1'b1;
        we_n = 1'b1;
        oe_n = 1'b1;
        addr_valid_n = 1'b1;
        addr = 13'h0000;
        data_in = 16'h0000;
    end
    // released lines show the inverse so a stale value never passes
    task automatic drive(input logic c, w, o, input logic [12:0] a, input logic [15:0] d);
        ce_n <= c;
        we_n <= w;
        oe_n <= o;
        addr_valid_n <= c;
        addr <= a;
        data_in <= d;
    endtask
    // write: strobes held two edges, then chip select dropped
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        drive(1'b0, 1'b0, 1'b1, a, {8'h00, d});
        repeat (2) @(posedge clk);
        drive(1'b1, 1'b1, 1'b1, ~a, ~{8'h00, d});
    endtask
    // read held n samples; three or more is the extended access
    task automatic rd(input logic [12:0] a, input int n, output logic [15:0] q);
        @(posedge clk);
        drive(1'b0, 1'b1, 1'b0, a, ~data_in);
        repeat (n) @(posedge clk);
        q = data_out;
        drive(1'b1, 1'b1, 1'b1, ~a, ~data_in);
    endtask
endmodule

// ---- verif/test_mode_and_partition_protect_ctrl.sv ----
// self-checking bench for the mode and partition protection controller
`timescale 1ns/1ps
`include "mppc_cfg.svh"
module test_mode_and_partition_protect_ctrl;
    import mppc_pkg::*;
    // ----------------
    // signals
    // ----------------
    logic           clk, rstn, hw_reset_in_n, lock_in_n, power_down_pin, boot_detect;
    logic           attr_change, flash_wr, ce_n, we_n, oe_n, addr_valid_n, data_oe;
    logic           session_lock_bit, in_buf_en;
    logic [9:0]     flash_wr_block;
    logic [12:0]    addr;
    logic [15:0]    data_in, data_out, q;
    logic [1:0]     part_rd_ok, part_wr_ok;
    mppc_mode_t     mode;
    mppc_part_cfg_t cfg [2];
    int             bad_count, checks, i;
    mppc_ctrl u_dut (
        .clk(clk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr_valid_n(addr_valid_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .mux_if(1'b0), .boot_rd_data(16'h3C5A), .hw_reset_in_n(hw_reset_in_n),
        .lock_in_n(lock_in_n), .power_down_pin(power_down_pin), .boot_detect(boot_detect),
        .part_cfg(cfg), .attr_change(attr_change), .flash_wr(flash_wr),
        .flash_wr_block(flash_wr_block), .mode(mode), .part_rd_ok(part_rd_ok),
        .part_wr_ok(part_wr_ok), .session_lock_bit(session_lock_bit), .in_buf_en(in_buf_en));
    mppc_host_model u_host (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr_valid_n(addr_valid_n), .addr(addr), .data_in(data_in), .data_out(data_out));
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // mode changes take a few edges, so poll with a bound
    task automatic want(input mppc_mode_t m);
        for (int k = 0; k < 16 && mode !== m; k++) @(posedge clk);
        idle(1);
        chk(mode, m);
    endtask
    task automatic req(input logic [1:0] m);
        u_host.wr(`MPPC_ADDR_MODE_CTL, {6'h00, m});
        u_host.wr(`MPPC_ADDR_MODE_CNF, ~{6'h00, m});
    endtask
    task automatic keys;
        u_host.wr(`MPPC_ADDR_KEY0, 8'h5A);
        u_host.wr(`MPPC_ADDR_KEY1, 8'hA5);
        idle(3);
    endtask
    task automatic summarize;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // the tests need well under 1500 cycles
    initial begin
        #300000;
        bad_count++;
        summarize();
    end
    // ----------------
    // test sequence
    // ----------------
    initial begin
        rstn = 1'b0;
        hw_reset_in_n = 1'b1;
        lock_in_n = 1'b1;
        power_down_pin = 1'b0;
        boot_detect = 1'b0;
        attr_change = 1'b0;
        flash_wr = 1'b0;
        flash_wr_block = 10'h000;
        cfg[0] = '{1'b1, 1'b1, 1'b1, 8'h5A};
        cfg[1] = '{1'b0, 1'b1, 1'b0, 8'hA5};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        idle(4);
        chk(mode, MPPC_RESET);
        u_host.rd(`MPPC_ADDR_OUT_CTL, 2, q);
        chk(q, 16'h0000);
        u_host.wr(`MPPC_ADDR_OUT_CTL, 8'h01);
        idle(3);
        chk(session_lock_bit, 1'b0);
        req(2'b01);
        want(MPPC_NORMAL);
        u_host.rd(`MPPC_ADDR_MODE_CTL, 2, q);
        chk(q, 16'h0001);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h0002);
        u_host.wr(`MPPC_ADDR_KEY0, 8'h5A);
        idle(3);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h0007);
        u_host.wr(`MPPC_ADDR_KEY1, 8'hA5);
        idle(3);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h000F);
        @(posedge clk) lock_in_n <= 1'b0;
        idle(4);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h000A);
        @(posedge clk) attr_change <= 1'b1;
        @(posedge clk) attr_change <= 1'b0;
        @(posedge clk) lock_in_n <= 1'b1;
        idle(4);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h0002);
        keys();
        flash_wr_block <= 10'h003;
        @(posedge clk) flash_wr <= 1'b1;
        @(posedge clk) flash_wr <= 1'b0;
        idle(3);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h0002);
        keys();
        u_host.wr(`MPPC_ADDR_OUT_CTL, 8'h01);
        u_host.wr(`MPPC_ADDR_OUT_CTL, 8'h00);
        idle(4);
        chk(session_lock_bit, 1'b1);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h000A);
        req(2'b10);
        want(MPPC_PDOWN);
        chk(in_buf_en, 1'b0);
        chk({12'h000, part_wr_ok, part_rd_ok}, 16'h0002);
        for (i = 0; i < 3; i++) u_host.rd(`MPPC_ADDR_WAKE, 2, q);
        idle(4);
        chk(mode, MPPC_PDOWN);
        u_host.rd(`MPPC_ADDR_WAKE, 2, q);
        want(MPPC_NORMAL);
        chk(session_lock_bit, 1'b1);
        req(2'b10);
        want(MPPC_PDOWN);
        u_host.rd(13'h0100, 3, q);
        want(MPPC_NORMAL);
        u_host.wr(`MPPC_ADDR_PD_CTL, 8'h01);
        @(posedge clk) power_down_pin <= 1'b1;
        want(MPPC_PDOWN);
        @(posedge clk) power_down_pin <= 1'b0;
        want(MPPC_NORMAL);
        req(2'b00);
        want(MPPC_RESET);
        req(2'b01);
        want(MPPC_NORMAL);
        @(posedge clk) boot_detect <= 1'b1;
        @(posedge clk) boot_detect <= 1'b0;
        want(MPPC_RESET);
        req(2'b01);
        want(MPPC_NORMAL);
        @(posedge clk) hw_reset_in_n <= 1'b0;
        want(MPPC_PDOWN);
        @(posedge clk) hw_reset_in_n <= 1'b1;
        want(MPPC_RESET);
        chk(session_lock_bit, 1'b0);
        summarize();
    end
endmodule
